// ### logic/ipj_pkg.sv
package ipj_pkg;

    localparam int IR_WIDTH = 8;
    localparam int DR_WIDTH = 32;
    localparam int BSR_WIDTH = 6;

    // Instruction codes
    localparam logic [7:0] INS_BYPASS = 8'hff;
    localparam logic [7:0] INS_SAMPLE = 8'h01;
    localparam logic [7:0] INS_EXTEST = 8'h00;
    localparam logic [7:0] INS_CLAMP = 8'hfa;
    localparam logic [7:0] INS_HIGHZ = 8'hfc;
    localparam logic [7:0] INS_IDCODE = 8'hfe;
    localparam logic [7:0] INS_USERCODE = 8'hfd;
    localparam logic [7:0] INS_CONFIG = 8'hee;
    // Programming instructions
    localparam logic [7:0] INS_ISP_ENABLE = 8'he8;
    localparam logic [7:0] INS_ISP_DISABLE = 8'hf0;
    localparam logic [7:0] INS_ERASE = 8'hec;
    localparam logic [7:0] INS_PROG_DATA = 8'hea;
    localparam logic [7:0] INS_READ_DATA = 8'hef;
    localparam logic [7:0] INS_PROG_USER = 8'he6;
    localparam logic [7:0] INS_SET_SECURE = 8'he3;

    // Capture pattern fields
    localparam logic [2:0] CAP_HIGH = 3'h0;
    localparam logic CAP_BIT2 = 1'b0;
    localparam logic [1:0] CAP_LOW = 2'h1;

    // Boundary cell positions, bit 0 nearest TDO
    localparam int BSR_CE = 5;
    localparam int BSR_OE_RESET = 4;
    localparam int BSR_DATA_VAL = 3;
    localparam int BSR_DATA_EN = 2;
    localparam int BSR_CEO_VAL = 1;
    localparam int BSR_CEO_EN = 0;

    // Reset and erased values
    localparam logic [31:0] ERASED_WORD = 32'hffffffff;
    localparam logic [7:0] IR_RESET = INS_IDCODE;

    // Restart pulse timing
    localparam int CLK_PERIOD_PS = 25000;
    localparam int RESTART_MIN_NS = 300;
    localparam int RESTART_MAX_NS = 500;
    localparam int RESTART_CYCLES = (RESTART_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RESTART_CYC_MAX = (RESTART_MAX_NS * 1000) / CLK_PERIOD_PS;

    typedef enum logic [2:0] {
        DR_BYPASS,
        DR_BOUNDARY,
        DR_IDCODE,
        DR_USERCODE,
        DR_PATTERN
    } ipj_dr_e;

    typedef struct packed {
        logic ce;
        logic oeReset;
        logic dataCore;
        logic dataCoreOe;
        logic ceoCore;
        logic ceoCoreOe;
    } ipj_pins_s;

    typedef struct packed {
        logic dataPin;
        logic dataOe;
        logic ceoPin;
        logic ceoOe;
    } ipj_pads_s;

endpackage

// ### logic/ipj_restart_pulse.sv
module ipj_restart_pulse
    import ipj_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic startToggle,
    output logic restartOut,
    output logic restartOe
);

    localparam int CNT_W = $clog2(RESTART_CYCLES + 1);
    localparam logic [CNT_W-1:0] PULSE_LEN = CNT_W'(RESTART_CYCLES);

    logic syncA_ff;
    logic syncB_ff;
    logic syncC_ff;
    logic [CNT_W-1:0] count_ff;

    // ---------------------------------------------
    // Toggle crossing from the test clock
    // ---------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            syncA_ff <= 1'b0;
            syncB_ff <= 1'b0;
            syncC_ff <= 1'b0;
        end
        else
        begin
            syncA_ff <= startToggle;
            syncB_ff <= syncA_ff;
            syncC_ff <= syncB_ff;
        end
    end

    // ---------------------------------------------
    // Pulse length counter
    // ---------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
            count_ff <= '0;
        else if (syncB_ff != syncC_ff)
            count_ff <= PULSE_LEN;
        else if (count_ff != '0)
            count_ff <= count_ff - 1'b1;
    end

    // Open drain: only ever pulls low
    assign restartOut = 1'b0;
    assign restartOe = (count_ff != '0);

endmodule

// ### logic/ipj_tap.sv
module ipj_tap
    import ipj_pkg::*;
#(
    parameter logic [31:0] ID_VALUE = 32'h0a5c3001 // Arbitrary value
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdoOe,
    input wire ipj_pins_s pinsIn,
    output ipj_pads_s padsOut,
    output logic restartOut,
    output logic restartOe,
    output logic programmingActiveFlag
);

    typedef enum logic [3:0] {
        TEST_RESET,
        RUN_IDLE,
        SEL_DR,
        CAP_DR,
        SHIFT_DR,
        EXIT1_DR,
        PAUSE_DR,
        EXIT2_DR,
        UPD_DR,
        SEL_IR,
        CAP_IR,
        SHIFT_IR,
        EXIT1_IR,
        PAUSE_IR,
        EXIT2_IR,
        UPD_IR
    } ipj_tap_e;

    // ---------------------------------------------
    // Register selection decode
    // ---------------------------------------------
    function automatic ipj_dr_e selectDr(input logic [7:0] code);
        unique case (code)
            INS_SAMPLE, INS_EXTEST: selectDr = DR_BOUNDARY;
            INS_IDCODE: selectDr = DR_IDCODE;
            INS_USERCODE: selectDr = DR_USERCODE;
            INS_PROG_DATA, INS_READ_DATA, INS_PROG_USER: selectDr = DR_PATTERN;
            default: selectDr = DR_BYPASS;
        endcase
    endfunction

    // Shifted code taking effect at Update-IR
    function automatic logic updIrIs(input ipj_tap_e st, input logic [7:0] shifted,
                                     input logic [7:0] code);
        updIrIs = (st == UPD_IR) && (shifted == code);
    endfunction

    logic rstSyncA_ff;
    logic rstTck_ff;
    ipj_pins_s pinsA_ff;
    ipj_pins_s pins_ff;
    ipj_tap_e state_ff;
    ipj_tap_e nxt_state;
    logic [7:0] irShift_ff;
    logic [7:0] instr_ff;
    logic [31:0] drShift_ff;
    logic [BSR_WIDTH-1:0] bsrUpdate_ff;
    logic [31:0] userCode_ff;
    logic [31:0] pattern_ff;
    logic secure_ff;
    logic ispMode_ff;
    logic restartToggle_ff;
    logic tdo_ff;
    logic tdoOe_ff;
    ipj_dr_e drSel;
    logic [31:0] idWord;
    logic extestOn;
    logic clampOn;
    logic highzOn;
    logic eraseNow;
    logic setSecureNow;

    assign drSel = selectDr(instr_ff);
    assign idWord = {ID_VALUE[31:1], 1'b1};
    // Erase and secure act only in programming mode
    assign eraseNow = ispMode_ff && updIrIs(state_ff, irShift_ff, INS_ERASE);
    assign setSecureNow = ispMode_ff && updIrIs(state_ff, irShift_ff, INS_SET_SECURE);

    // ---------------------------------------------
    // Reset and pin synchronisers on test clock
    // ---------------------------------------------
    always_ff @(posedge tck)
    begin
        rstSyncA_ff <= rst;
        rstTck_ff <= rstSyncA_ff;
    end

    always_ff @(posedge tck)
    begin
        if (rstTck_ff)
        begin
            pinsA_ff <= '0;
            pins_ff <= '0;
        end
        else
        begin
            pinsA_ff <= pinsIn;
            pins_ff <= pinsA_ff;
        end
    end

    // ---------------------------------------------
    // TAP controller
    // ---------------------------------------------
    always_comb
    begin
        unique case (state_ff)
            TEST_RESET: nxt_state = tms ? TEST_RESET : RUN_IDLE;
            RUN_IDLE: nxt_state = tms ? SEL_DR : RUN_IDLE;
            SEL_DR: nxt_state = tms ? SEL_IR : CAP_DR;
            CAP_DR: nxt_state = tms ? EXIT1_DR : SHIFT_DR;
            SHIFT_DR: nxt_state = tms ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR: nxt_state = tms ? UPD_DR : PAUSE_DR;
            PAUSE_DR: nxt_state = tms ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR: nxt_state = tms ? UPD_DR : SHIFT_DR;
            UPD_DR: nxt_state = tms ? SEL_DR : RUN_IDLE;
            SEL_IR: nxt_state = tms ? TEST_RESET : CAP_IR;
            CAP_IR: nxt_state = tms ? EXIT1_IR : SHIFT_IR;
            SHIFT_IR: nxt_state = tms ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR: nxt_state = tms ? UPD_IR : PAUSE_IR;
            PAUSE_IR: nxt_state = tms ? EXIT2_IR : PAUSE_IR;
            EXIT2_IR: nxt_state = tms ? UPD_IR : SHIFT_IR;
            UPD_IR: nxt_state = tms ? SEL_DR : RUN_IDLE;
        endcase
    end

    always_ff @(posedge tck)
    begin
        if (rstTck_ff)
            state_ff <= TEST_RESET;
        else
            state_ff <= nxt_state;
    end

    // ---------------------------------------------
    // Instruction register
    // ---------------------------------------------
    always_ff @(posedge tck)
    begin
        if (rstTck_ff)
            irShift_ff <= '0;
        else if (state_ff == CAP_IR)
            irShift_ff <= {CAP_HIGH, ispMode_ff, secure_ff, CAP_BIT2, CAP_LOW};
        else if (state_ff == SHIFT_IR)
            irShift_ff <= {tdi, irShift_ff[7:1]};
    end

    always_ff @(posedge tck)
    begin
        if (rstTck_ff || state_ff == TEST_RESET)
            instr_ff <= IR_RESET;
        else if (state_ff == UPD_IR)
            instr_ff <= irShift_ff;
    end

    // ---------------------------------------------
    // Data register shift path
    // ---------------------------------------------
    always_ff @(posedge tck)
    begin
        if (rstTck_ff)
            drShift_ff <= '0;
        else if (state_ff == CAP_DR)
        begin
            unique case (drSel)
                DR_BYPASS: drShift_ff <= '0;
                DR_BOUNDARY: drShift_ff <= {26'h0, pins_ff};
                DR_IDCODE: drShift_ff <= idWord;
                DR_USERCODE: drShift_ff <= userCode_ff;
                DR_PATTERN: drShift_ff <= secure_ff ? '0 : pattern_ff;
            endcase
        end
        else if (state_ff == SHIFT_DR)
        begin
            unique case (drSel)
                DR_BYPASS: drShift_ff <= {31'h0, tdi};
                DR_BOUNDARY: drShift_ff <= {26'h0, tdi, drShift_ff[BSR_WIDTH-1:1]};
                DR_IDCODE, DR_USERCODE, DR_PATTERN: drShift_ff <= {tdi, drShift_ff[31:1]};
            endcase
        end
    end

    // Boundary update stage, loaded for sample/preload and extest
    always_ff @(posedge tck)
    begin
        if (rstTck_ff)
            bsrUpdate_ff <= '0;
        else if (state_ff == UPD_DR && drSel == DR_BOUNDARY)
            bsrUpdate_ff <= drShift_ff[BSR_WIDTH-1:0];
    end

    // ---------------------------------------------
    // Programming mode, security and stored words
    // ---------------------------------------------
    always_ff @(posedge tck)
    begin
        if (rstTck_ff)
            ispMode_ff <= 1'b0;
        else if (updIrIs(state_ff, irShift_ff, INS_ISP_ENABLE))
            ispMode_ff <= 1'b1;
        else if (updIrIs(state_ff, irShift_ff, INS_ISP_DISABLE))
            ispMode_ff <= 1'b0;
    end

    always_ff @(posedge tck)
    begin
        if (rstTck_ff)
            secure_ff <= 1'b0;
        else if (eraseNow)
            secure_ff <= 1'b0;
        else if (setSecureNow)
            secure_ff <= 1'b1;
    end

    always_ff @(posedge tck)
    begin
        if (rstTck_ff)
            userCode_ff <= ERASED_WORD;
        else if (eraseNow)
            userCode_ff <= ERASED_WORD;
        else if (ispMode_ff && !secure_ff && state_ff == UPD_DR && instr_ff == INS_PROG_USER)
            userCode_ff <= drShift_ff;
    end

    always_ff @(posedge tck)
    begin
        if (rstTck_ff)
            pattern_ff <= ERASED_WORD;
        else if (eraseNow)
            pattern_ff <= ERASED_WORD;
        else if (ispMode_ff && !secure_ff && state_ff == UPD_DR && instr_ff == INS_PROG_DATA)
            pattern_ff <= drShift_ff;
    end

    // Config launch crosses as a toggle
    always_ff @(posedge tck)
    begin
        if (rstTck_ff)
            restartToggle_ff <= 1'b0;
        else if (updIrIs(state_ff, irShift_ff, INS_CONFIG))
            restartToggle_ff <= ~restartToggle_ff;
    end

    // ---------------------------------------------
    // Test data output on falling edge
    // ---------------------------------------------
    always_ff @(negedge tck)
    begin
        if (rstTck_ff)
        begin
            tdo_ff <= 1'b0;
            tdoOe_ff <= 1'b0;
        end
        else
        begin
            tdo_ff <= (state_ff == SHIFT_IR) ? irShift_ff[0] : drShift_ff[0];
            tdoOe_ff <= (state_ff == SHIFT_IR) || (state_ff == SHIFT_DR);
        end
    end

    assign tdo = tdo_ff;
    assign tdoOe = tdoOe_ff;

    // ---------------------------------------------
    // Pin control
    // ---------------------------------------------
    assign extestOn = (instr_ff == INS_EXTEST);
    assign clampOn = (instr_ff == INS_CLAMP);
    assign highzOn = (instr_ff == INS_HIGHZ) || (ispMode_ff && !clampOn);

    always_comb
    begin
        if (highzOn)
        begin
            padsOut.dataPin = 1'b0;
            padsOut.dataOe = 1'b0;
            padsOut.ceoPin = 1'b0;
            padsOut.ceoOe = 1'b0;
        end
        else if (extestOn || clampOn)
        begin
            padsOut.dataPin = bsrUpdate_ff[BSR_DATA_VAL];
            padsOut.dataOe = bsrUpdate_ff[BSR_DATA_EN];
            padsOut.ceoPin = bsrUpdate_ff[BSR_CEO_VAL];
            padsOut.ceoOe = bsrUpdate_ff[BSR_CEO_EN];
        end
        else
        begin
            padsOut.dataPin = pinsIn.dataCore;
            padsOut.dataOe = pinsIn.dataCoreOe;
            padsOut.ceoPin = pinsIn.ceoCore;
            padsOut.ceoOe = pinsIn.ceoCoreOe;
        end
    end

    assign programmingActiveFlag = ispMode_ff;

    // ---------------------------------------------
    // FPGA restart pulse in the system clock domain
    // ---------------------------------------------
    ipj_restart_pulse restartGen (
        .clk(clk),
        .rst(rst),
        .startToggle(restartToggle_ff),
        .restartOut(restartOut),
        .restartOe(restartOe)
    );

endmodule

// ### test/ipj_tap_assertions.sv
module ipj_tap_assertions
    import ipj_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo,
    input wire logic tdoOe,
    input wire ipj_pins_s pinsIn,
    input wire ipj_pads_s padsOut,
    input wire logic restartOut,
    input wire logic restartOe,
    input wire logic programmingActiveFlag
);
    // ------------------------------
    // Restart pulse, system clock
    // ------------------------------
    sequence s_twelveHigh;
        restartOe [*8] ##1 restartOe [*4];
    endsequence
    property p_restartWidth;
        @(posedge clk) disable iff (rst)
        $rose(restartOe) |-> s_twelveHigh ##1 !restartOe;
    endproperty
    a_restartWidth: assert property (p_restartWidth)
        else $error("restart pulse width wrong");
    property p_restartLow;
        @(posedge clk) disable iff (rst) restartOut == 1'b0;
    endproperty
    a_restartLow: assert property (p_restartLow)
        else $error("restart value not low");
    property p_restartQuiet;
        @(posedge clk) disable iff (rst) $fell(rst) |-> !restartOe;
    endproperty
    a_restartQuiet: assert property (p_restartQuiet)
        else $error("restart active out of reset");
    // ------------------------------
    // Test clock domain
    // ------------------------------
    property p_resetFlags;
        @(posedge tck) disable iff (rst)
        $fell(rst) |-> !programmingActiveFlag && !tdoOe && tdo == 1'b0;
    endproperty
    a_resetFlags: assert property (p_resetFlags)
        else $error("mode or scan output set after reset");
    property p_padsReset;
        @(posedge tck) disable iff (rst) $fell(rst) |->
        padsOut == {pinsIn.dataCore, pinsIn.dataCoreOe, pinsIn.ceoCore, pinsIn.ceoCoreOe};
    endproperty
    a_padsReset: assert property (p_padsReset)
        else $error("pads not functional after reset");
    property p_shiftStay;
        @(posedge tck) disable iff (rst) tdoOe && !tms |=> tdoOe;
    endproperty
    a_shiftStay: assert property (p_shiftStay)
        else $error("scan output dropped while shifting");
    property p_shiftLeave;
        @(posedge tck) disable iff (rst) tdoOe && tms |=> !tdoOe;
    endproperty
    a_shiftLeave: assert property (p_shiftLeave)
        else $error("scan output kept after shift exit");
    sequence s_fiveOnes;
        tms [*5];
    endsequence
    property p_tlrQuiet;
        @(posedge tck) disable iff (rst) s_fiveOnes |=> !tdoOe;
    endproperty
    a_tlrQuiet: assert property (p_tlrQuiet)
        else $error("scan output on in logic reset");
endmodule

bind ipj_tap ipj_tap_assertions ipj_tap_assertions_i (
    .clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdoOe(tdoOe), .pinsIn(pinsIn), .padsOut(padsOut), .restartOut(restartOut),
    .restartOe(restartOe), .programmingActiveFlag(programmingActiveFlag)
);

// ### test/ipj_jtag_host.sv
module ipj_jtag_host
(
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdoLine
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------
    // Test clock runs only inside frames
    // ------------------------------
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #6;
        q = tdoLine;
        tck = 1'b1;
        #6;
        tck = 1'b0;
    endtask
    task automatic idle(input int n, input logic m);
        logic q;
        repeat (n) step(m, ~tdi, q);
    endtask
    // Idle to idle scan, low bit first
    task automatic scan(input logic isIr, input int n, input logic [31:0] d,
                        output logic [31:0] q);
        logic b;
        q = '0;
        step(1'b1, ~tdi, b);
        if (isIr)
            step(1'b1, ~tdi, b);
        step(1'b0, ~tdi, b);
        step(1'b0, ~tdi, b);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, d[i], b);
            q[i] = b;
        end
        step(1'b1, ~d[n-1], b);
        step(1'b0, d[n-1], b);
    endtask
endmodule

// ### test/ipj_tap_tb.sv
module ipj_tap_tb import ipj_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] ID_SET = 32'h12345670; // Arbitrary value
    localparam ipj_pins_s PINS = 6'h2d;
    logic clk, rst, tck, tms, tdi, tdo, tdoOe, restartOut, restartOe, progFlag;
    ipj_pins_s pinsIn;
    ipj_pads_s padsOut;
    logic [31:0] q;
    int errCount = 0;
    int compares = 0;
    int n;
    int k;
    wire logic tdoLine = tdoOe ? tdo : 1'b1;

    ipj_tap #(.ID_VALUE(ID_SET)) ipj_tap_i (
        .clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdoOe(tdoOe), .pinsIn(pinsIn), .padsOut(padsOut), .restartOut(restartOut),
        .restartOe(restartOe), .programmingActiveFlag(progFlag)
    );
    ipj_jtag_host ipj_jtag_host_i (.tck(tck), .tms(tms), .tdi(tdi), .tdoLine(tdoLine));

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ------------------------------
    // Checking and scan helpers
    // ------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            errCount++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wrapUp;
        $display("compares %0d mismatches %0d", compares, errCount);
        if (errCount == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic ir(input logic [7:0] c, input logic [7:0] e);
        ipj_jtag_host_i.scan(1'b1, 8, {24'h0, c}, q);
        chk("capture", q, {24'h0, e});
    endtask
    task automatic dr(input int w, input logic [31:0] d, input logic [31:0] e, input string nm);
        ipj_jtag_host_i.scan(1'b0, w, d, q);
        chk(nm, q, e);
    endtask
    function automatic logic [31:0] oes();
        return {30'h0, padsOut.dataOe, padsOut.ceoOe};
    endfunction
    // ------------------------------
    // Main sequence
    // ------------------------------
    initial
    begin
        rst <= 1'b1;
        pinsIn <= PINS;
        repeat (4) @(posedge clk);
        ipj_jtag_host_i.idle(6, 1'b1);
        @(posedge clk);
        rst <= 1'b0;
        ipj_jtag_host_i.idle(5, 1'b1);
        ipj_jtag_host_i.idle(1, 1'b0);
        dr(32, 32'h0, ID_SET | 32'h1, "id after reset");
        ir(INS_BYPASS, 8'h01);
        dr(32, 32'h80000003, 32'h6, "bypass");
        ir(INS_IDCODE, 8'h01);
        dr(32, 32'h0, ID_SET | 32'h1, "idcode");
        ir(INS_USERCODE, 8'h01);
        dr(32, 32'h0, ERASED_WORD, "blank user");
        ir(8'h5a, 8'h01);
        dr(32, 32'h80000003, 32'h6, "unlisted");
        ir(INS_SAMPLE, 8'h01);
        dr(6, 32'h06, {26'h0, PINS}, "sample");
        ir(INS_EXTEST, 8'h01);
        chk("extest pads", {28'h0, padsOut}, 32'h6);
        ir(INS_CLAMP, 8'h01);
        chk("clamp pads", {28'h0, padsOut}, 32'h6);
        dr(32, 32'h80000003, 32'h6, "clamp bypass");
        ir(INS_HIGHZ, 8'h01);
        chk("highz", oes(), 32'h0);
        ir(INS_ISP_ENABLE, 8'h01);
        chk("mode flag", {31'h0, progFlag}, 32'h1);
        chk("isp float", oes(), 32'h0);
        ir(INS_CLAMP, 8'h11);
        chk("isp clamp", {28'h0, padsOut}, 32'h6);
        ir(INS_PROG_DATA, 8'h11);
        ipj_jtag_host_i.scan(1'b0, 32, 32'hc3a55a3c, q);
        ir(INS_READ_DATA, 8'h11);
        dr(32, 32'h0, 32'hc3a55a3c, "readback");
        ir(INS_PROG_USER, 8'h11);
        ipj_jtag_host_i.scan(1'b0, 32, 32'h13579bdf, q);
        ir(INS_USERCODE, 8'h11);
        dr(32, 32'h0, 32'h13579bdf, "user");
        ir(INS_SET_SECURE, 8'h11);
        ir(INS_READ_DATA, 8'h19);
        dr(32, 32'h0, 32'h0, "secured read");
        ir(INS_ISP_DISABLE, 8'h19);
        ir(INS_ISP_ENABLE, 8'h09);
        ipj_jtag_host_i.idle(5, 1'b1);
        ipj_jtag_host_i.idle(1, 1'b0);
        ir(INS_ERASE, 8'h19);
        ir(INS_USERCODE, 8'h11);
        dr(32, 32'h0, ERASED_WORD, "erased user");
        ir(INS_ISP_DISABLE, 8'h11);
        ir(INS_BYPASS, 8'h01);
        chk("mode off", {31'h0, progFlag}, 32'h0);
        chk("functional pads", {28'h0, padsOut}, 32'hd);
        ir(INS_CONFIG, 8'h01);
        n = 0;
        k = 0;
        while (restartOe !== 1'b1 && k < 20)
        begin
            @(negedge clk);
            k++;
        end
        while (restartOe === 1'b1 && n < 40)
        begin
            @(negedge clk);
            n++;
        end
        chk("restart width", n, 32'd12);
        chk("restart value", {31'h0, restartOut}, 32'h0);
        wrapUp();
    end

    initial
    begin
        #100us;
        errCount++;
        wrapUp();
    end
endmodule
